//--- bench/psv_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Sending host: register master and returns
module psv_host_model (
  input wire clk_sys,
  input wire [31:0] reg_rdata,
  output reg [7:0] reg_addr,
  output reg [31:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd,
  output reg cr_in
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cr_in = 1'b0;
  end
  // Nonblocking drives after the rising edge so a strobe is never set twice in one step
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
    end
  endtask
  task cr;
    begin
      cr_in <= 1'b1;
      @(posedge clk_sys);
      cr_in <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
endmodule // psv_host_model

//--- bench/psv_setup_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Checker on the setup block ports
module psv_setup_chk (
  input wire clk_sys,
  input wire rst_n,
  input wire alternate_rate_set,
  input wire cr_in,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [13:0] baud_rate,
  input wire parallel_in_sel,
  input wire self_test_en,
  input wire auto_lf_en,
  input wire perf_skip_en,
  input wire eight_line_spacing,
  input wire motor_step,
  input wire [7:0] line_count
);
  reg [7:0] line_prev;
  reg [3:0] step_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Steps seen since the last line change
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      line_prev <= 8'h00;
      step_cnt <= 4'h0;
    end else begin
      line_prev <= line_count;
      step_cnt <= (line_count != line_prev) ? {3'h0, motor_step} : step_cnt + {3'h0, motor_step};
    end
  end
  // ==========================================
  // Properties
  a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_reset_vals: assert property ($rose(rst_n) |-> baud_rate == 14'h006e && self_test_en && auto_lf_en
    && perf_skip_en && !parallel_in_sel && line_count == 8'h00 && !eight_line_spacing)
    else $error("wrong values after reset");
  a_par_no_test: assert property (parallel_in_sel |-> !self_test_en && baud_rate == 14'h0000)
    else $error("parallel input with self test or rate");
  a_baud_set: assert property ($stable(alternate_rate_set) |-> (alternate_rate_set ?
    !(baud_rate inside {14'h0096, 14'h12c0}) : !(baud_rate inside {14'h00c8, 14'h0258})))
    else $error("rate from wrong set");
  a_step_gap: assert property (motor_step |=> !motor_step [*2])
    else $error("motor steps too close");
  a_step_count: assert property ((line_count != line_prev) && (line_count == line_prev + 8'h01)
    |-> step_cnt == (eight_line_spacing ? 4'h9 : 4'hc))
    else $error("wrong step count for one line");
  a_line_step: assert property ($changed(line_count) |->
    (line_count == $past(line_count) + 8'h01) || (line_count == 8'h00))
    else $error("line counter jumped");
  a_cr_feed: assert property (cr_in && auto_lf_en |-> ##[1:80] motor_step)
    else $error("no line feed after return");
endmodule // psv_setup_chk

bind psv_setup psv_setup_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .alternate_rate_set(alternate_rate_set),
  .cr_in(cr_in), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_rate(baud_rate),
  .parallel_in_sel(parallel_in_sel), .self_test_en(self_test_en), .auto_lf_en(auto_lf_en),
  .perf_skip_en(perf_skip_en), .eight_line_spacing(eight_line_spacing), .motor_step(motor_step),
  .line_count(line_count));

//--- bench/psv_setup_tb.sv
`timescale 1ns/1ps
module psv_setup_tb;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [6:0] pencil_sw = 7'h00;
  reg alternate_rate_set = 1'b0;
  reg format_control_config = 1'b0;
  reg mode_select_switch = 1'b0;
  reg [7:0] btn = 8'h00;
  reg [2:0] channel_sel = 3'h0;
  wire [7:0] reg_addr, line_count;
  wire [31:0] reg_wdata, reg_rdata;
  wire [13:0] baud_rate;
  wire reg_wr, reg_rd, cr_in, parallel_in_sel, self_test_en, parity_check_en, parity_odd;
  wire auto_lf_en, perf_skip_en, eight_line_spacing, motor_step;
  integer bad_count = 0;
  integer n_compared = 0;
  integer n_steps = 0;
  reg [31:0] rv;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (motor_step === 1'b1) n_steps = n_steps + 1;
  psv_host_model host_u (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .cr_in(cr_in));
  // Short debounce and step counts keep the run brief
  psv_setup #(.DEB_CYC(4), .STEP_CYC(3)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
    .pencil_sw(pencil_sw), .alternate_rate_set(alternate_rate_set), .format_control_config(format_control_config),
    .mode_select_switch(mode_select_switch), .btn_set_top(btn[0]), .btn_tab_set(btn[1]), .btn_tab_clear(btn[2]),
    .btn_tab(btn[3]), .btn_line_feed(btn[4]), .btn_lpi(btn[5]), .btn_store(btn[6]), .btn_recall(btn[7]),
    .channel_sel(channel_sel), .cr_in(cr_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_rate(baud_rate), .parallel_in_sel(parallel_in_sel),
    .self_test_en(self_test_en), .parity_check_en(parity_check_en), .parity_odd(parity_odd),
    .auto_lf_en(auto_lf_en), .perf_skip_en(perf_skip_en), .eight_line_spacing(eight_line_spacing),
    .motor_step(motor_step), .line_count(line_count));
  // ==========================================
  // Helpers
  task cyc(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      host_u.rd(a, rv);
      check(rv, exp);
    end
  endtask
  task do_reset;
    begin
      rst_n <= 1'b0;
      cyc(5);
      rst_n <= 1'b1;
      @(posedge clk_sys);
    end
  endtask
  task press(input integer i);
    begin
      btn[i] <= 1'b1;
      cyc(10);
      btn[i] <= 1'b0;
      cyc(10);
    end
  endtask
  task wait_line(input [7:0] exp);
    integer k;
    begin
      for (k = 0; k < 400 && line_count !== exp; k = k + 1) @(posedge clk_sys);
      check(line_count, exp);
    end
  endtask
  function [13:0] exp_baud(input [2:0] c, input a);
    case (c)
      3'h0: exp_baud = 14'h006e;
      3'h1: exp_baud = a ? 14'h00c8 : 14'h0096;
      3'h2: exp_baud = 14'h012c;
      3'h3: exp_baud = 14'h04b0;
      3'h4: exp_baud = 14'h0960;
      3'h5: exp_baud = a ? 14'h0258 : 14'h12c0;
      3'h6: exp_baud = 14'h2580;
      default: exp_baud = 14'h0000;
    endcase
  endfunction
  task complete_run;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_switches;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        pencil_sw <= {4'h0, i[2:0]};
        alternate_rate_set <= i[3];
        cyc(12);
        check(baud_rate, exp_baud(i[2:0], i[3]));
        check(parallel_in_sel, i[2:0] == 3'h7);
        check(self_test_en, i[2:0] != 3'h7);
      end
      for (i = 0; i < 16; i = i + 1) begin
        pencil_sw <= {i[3:0], 3'h0};
        cyc(12);
        check(parity_check_en, i[0] & 1'b1);
        if (i[0]) check(parity_odd, i[1] & 1'b1);
        check(auto_lf_en, !i[2]);
        check(perf_skip_en, !i[3]);
      end
      pencil_sw <= 7'h00;
      cyc(12);
      rchk(8'h00, 32'h30);
      rchk(8'h04, 32'h6e);
    end
  endtask
  task t_form;
    begin
      rchk(8'h08, 32'h42);
      rchk(8'h20, 32'h0);
      host_u.wr(8'h08, 32'h30);
      rchk(8'h08, 32'h30);
      do_reset;
      rchk(8'h08, 32'h42);
    end
  endtask
  task t_motion;
    begin
      n_steps = 0;
      host_u.wr(8'h10, 32'h4);
      wait_line(8'h01);
      check(n_steps, 12);
      host_u.wr(8'h10, 32'h8);
      cyc(1);
      check(eight_line_spacing, 1);
      n_steps = 0;
      host_u.wr(8'h10, 32'h4);
      wait_line(8'h02);
      check(n_steps, 9);
      host_u.cr;
      wait_line(8'h03);
      pencil_sw <= 7'h20;
      cyc(12);
      host_u.cr;
      cyc(100);
      check(line_count, 3);
      pencil_sw <= 7'h00;
      host_u.wr(8'h10, 32'h10);
      cyc(1);
      check(eight_line_spacing, 0);
      press(0);
      check(line_count, 3);
    end
  endtask
  task t_format;
    begin
      mode_select_switch <= 1'b1;
      cyc(12);
      press(5);
      check(eight_line_spacing, 1);
      press(0);
      check(line_count, 0);
      press(4);
      wait_line(8'h01);
      press(4);
      wait_line(8'h02);
      press(1);
      press(4);
      wait_line(8'h03);
      press(4);
      wait_line(8'h04);
      press(0);
      mode_select_switch <= 1'b0;
      cyc(12);
      rchk(8'h08, 32'h4);
      mode_select_switch <= 1'b1;
      cyc(12);
      press(3);
      wait_line(8'h02);
      press(3);
      wait_line(8'h00);
      press(3);
      wait_line(8'h02);
      press(2);
      press(4);
      wait_line(8'h03);
      press(4);
      wait_line(8'h00);
      press(3);
      cyc(200);
      check(line_count, 0);
    end
  endtask
  task t_store;
    begin
      format_control_config <= 1'b1;
      host_u.wr(8'h10, 32'h301);
      host_u.wr(8'h08, 32'h10);
      host_u.wr(8'h10, 32'h10);
      host_u.wr(8'h10, 32'h302);
      rchk(8'h08, 32'h4);
      check(eight_line_spacing, 1);
      channel_sel <= 3'h5;
      host_u.wr(8'h08, 32'h20);
      cyc(12);
      press(6);
      host_u.wr(8'h08, 32'h11);
      press(7);
      rchk(8'h08, 32'h20);
      do_reset;
      cyc(5);
      rchk(8'h08, 32'h20);
    end
  endtask
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_form;
    t_switches;
    t_motion;
    t_format;
    t_store;
    complete_run;
  end
  initial begin
    #300000;
    bad_count = bad_count + 1;
    complete_run;
  end
endmodule // psv_setup_tb

//--- hw/psv_debounce.v
`timescale 1ns/1ps
`include "psv_regs.vh"
module psv_debounce #(
  parameter integer W = 20,
  parameter integer CYC = `PSV_DEB_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [W-1:0] raw,
  output reg [W-1:0] level,
  output reg [W-1:0] rise
);
  localparam integer LIM_I = CYC - 1;
  localparam [19:0] LIM = LIM_I[19:0];
  genvar i;
  // ==========================================
  // Per input synchroniser and settle counter
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg [19:0] cnt_reg;
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          cnt_reg <= 20'h00000;
          level[i] <= 1'b0;
          rise[i] <= 1'b0;
        end else if (clk_en) begin
          s1_reg <= raw[i];
          s2_reg <= s1_reg;
          rise[i] <= 1'b0;
          if (s2_reg == level[i]) begin
            cnt_reg <= 20'h00000;
          end else if (cnt_reg == LIM) begin
            cnt_reg <= 20'h00000;
            level[i] <= s2_reg;
            rise[i] <= s2_reg;
          end else begin
            cnt_reg <= cnt_reg + 20'h00001;
          end
        end
      end
    end
  endgenerate
endmodule // psv_debounce

//--- hw/psv_fmt_store.v
`timescale 1ns/1ps
module psv_fmt_store (
  input wire clk_sys,
  input wire clk_en,
  input wire wr_en,
  input wire [2:0] wr_ch,
  input wire [264:0] wr_data,
  input wire rd_en,
  input wire [2:0] rd_ch,
  output reg [264:0] rd_data,
  output reg [2:0] last_ch
);
  // ==========================================
  // Channel array
  // No reset here: contents stand in for the non-volatile part
  reg [264:0] mem [0:7];
  always @(posedge clk_sys) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_ch] <= wr_data;
        last_ch <= wr_ch;
      end
      if (rd_en) begin
        rd_data <= mem[rd_ch];
        last_ch <= rd_ch;
      end
    end
  end
endmodule // psv_fmt_store

//--- hw/psv_setup.v
`timescale 1ns/1ps
`include "psv_regs.vh"
module psv_setup #(
  parameter integer DEB_CYC = `PSV_DEB_CYC,
  parameter integer STEP_CYC = `PSV_STEP_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [6:0] pencil_sw,
  input wire alternate_rate_set,
  input wire format_control_config,
  input wire mode_select_switch,
  input wire btn_set_top,
  input wire btn_tab_set,
  input wire btn_tab_clear,
  input wire btn_tab,
  input wire btn_line_feed,
  input wire btn_lpi,
  input wire btn_store,
  input wire btn_recall,
  input wire [2:0] channel_sel,
  input wire cr_in,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg [13:0] baud_rate,
  output reg parallel_in_sel,
  output reg self_test_en,
  output reg parity_check_en,
  output reg parity_odd,
  output reg auto_lf_en,
  output reg perf_skip_en,
  output reg eight_line_spacing,
  output reg motor_step,
  output reg [7:0] line_count
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_STEP = 3'b010;
  localparam [2:0] ST_GAP = 3'b100;
  localparam integer STEP_LIM_I = STEP_CYC - 1;
  localparam [19:0] STEP_LIM = STEP_LIM_I[19:0];
  // Bit positions in the debounced bundle
  localparam integer IX_MODE = 7;
  localparam integer IX_TOP = 8;
  localparam integer IX_TSET = 9;
  localparam integer IX_TCLR = 10;
  localparam integer IX_TAB = 11;
  localparam integer IX_LF = 12;
  localparam integer IX_LPI = 13;
  localparam integer IX_STORE = 14;
  localparam integer IX_RECALL = 15;

  // ==========================================
  // Debounced panel inputs
  wire [19:0] deb_lvl;
  wire [19:0] deb_rise;
  psv_debounce #(.W(20), .CYC(DEB_CYC)) u_deb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .raw({
      channel_sel,
      btn_recall,
      btn_store,
      btn_lpi,
      btn_line_feed,
      btn_tab,
      btn_tab_clear,
      btn_tab_set,
      btn_set_top,
      mode_select_switch,
      pencil_sw
    }),
    .level(deb_lvl),
    .rise(deb_rise)
  );
  wire [6:0] sw = deb_lvl[6:0];
  wire fmt_mode = deb_lvl[IX_MODE];
  wire [2:0] sel_ch = deb_lvl[19:17];
  // Alternate functions gated by the mode switch; line feed is not gated
  wire p_top = deb_rise[IX_TOP] & fmt_mode;
  wire p_tset = deb_rise[IX_TSET] & fmt_mode;
  wire p_tclr = deb_rise[IX_TCLR] & fmt_mode;
  wire p_tab = deb_rise[IX_TAB] & fmt_mode;
  wire p_lf = deb_rise[IX_LF];
  wire p_lpi = deb_rise[IX_LPI] & fmt_mode;
  wire p_store = deb_rise[IX_STORE] & fmt_mode;
  wire p_recall = deb_rise[IX_RECALL] & fmt_mode;

  // ==========================================
  // Software commands
  wire cmd_wr = reg_wr && (reg_addr == `PSV_REG_CMD);
  wire form_wr = reg_wr && (reg_addr == `PSV_REG_FORM);
  wire [2:0] cmd_ch = reg_wdata[`PSV_CMD_CH_HI:`PSV_CMD_CH_LO];
  wire sw_store = cmd_wr & reg_wdata[`PSV_CMD_STORE];
  wire sw_recall = cmd_wr & reg_wdata[`PSV_CMD_RECALL];
  wire sw_lf = cmd_wr & reg_wdata[`PSV_CMD_LF];

  // ==========================================
  // Working format
  reg [7:0] form_len_reg;
  reg [255:0] tabs_reg;
  reg lpi8_reg;
  reg learn_reg;
  reg cap_valid_reg;
  reg [7:0] cap_len_reg;
  reg fmt_mode_q_reg;
  reg pu_recall_reg;
  reg recall_pend_reg;
  reg [2:0] state_reg;
  reg [3:0] steps_reg;
  reg [19:0] timer_reg;
  reg [7:0] lines_left_reg;
  reg tab_run_reg;
  wire [264:0] st_rd;
  wire [2:0] last_ch;
  wire fcc = format_control_config;

  wire do_store = fcc & (p_store | sw_store);
  wire do_recall = fcc & (p_recall | sw_recall | pu_recall_reg);
  wire [2:0] rec_ch = pu_recall_reg ? last_ch : (sw_recall ? cmd_ch : sel_ch);
  wire [2:0] sto_ch = sw_store ? cmd_ch : sel_ch;

  psv_fmt_store u_store (
    .clk_sys(clk_sys),
    .clk_en(clk_en),
    .wr_en(do_store),
    .wr_ch(sto_ch),
    .wr_data({form_len_reg, lpi8_reg, tabs_reg}),
    .rd_en(do_recall),
    .rd_ch(rec_ch),
    .rd_data(st_rd),
    .last_ch(last_ch)
  );

  // ==========================================
  // Line counter next value
  reg [7:0] next_line;
  always @* begin
    next_line = line_count + 8'h01;
    if (learn_reg) begin
      if (line_count == 8'hff) begin
        next_line = 8'hff;
      end
    end else if (next_line >= form_len_reg) begin
      next_line = 8'h00;
    end
  end
  wire line_done = (state_reg == ST_GAP) && (timer_reg == STEP_LIM) && (steps_reg == 4'h1);
  wire tab_stop = tabs_reg[next_line] || (next_line == 8'h00);

  // ==========================================
  // Working format registers
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      form_len_reg <= `PSV_FORM_LEN_RST;
      tabs_reg <= 256'h0;
      lpi8_reg <= 1'b0;
      learn_reg <= 1'b0;
      cap_valid_reg <= 1'b0;
      cap_len_reg <= 8'h00;
      fmt_mode_q_reg <= 1'b0;
      pu_recall_reg <= 1'b1;
      recall_pend_reg <= 1'b0;
      line_count <= 8'h00;
    end else if (clk_en) begin
      fmt_mode_q_reg <= fmt_mode;
      pu_recall_reg <= 1'b0;
      recall_pend_reg <= do_recall;
      if (form_wr) begin
        form_len_reg <= reg_wdata[7:0];
      end
      if (cmd_wr && reg_wdata[`PSV_CMD_LPI8]) begin
        lpi8_reg <= 1'b1;
      end else if (cmd_wr && reg_wdata[`PSV_CMD_LPI6]) begin
        lpi8_reg <= 1'b0;
      end
      if (p_lpi) begin
        lpi8_reg <= 1'b1;
      end
      if (line_done) begin
        line_count <= next_line;
      end
      if (p_tset) begin
        tabs_reg[line_count] <= 1'b1;
      end else if (p_tclr) begin
        tabs_reg[line_count] <= 1'b0;
      end
      if (p_top) begin
        line_count <= 8'h00;
        learn_reg <= ~learn_reg;
        if (learn_reg) begin
          cap_len_reg <= line_count;
          cap_valid_reg <= 1'b1;
        end else begin
          cap_valid_reg <= 1'b0;
        end
      end
      // Length only takes effect on return to normal
      if (fmt_mode_q_reg && !fmt_mode) begin
        learn_reg <= 1'b0;
        cap_valid_reg <= 1'b0;
        if (cap_valid_reg && cap_len_reg != 8'h00) begin
          form_len_reg <= cap_len_reg;
        end
      end
      if (recall_pend_reg) begin
        form_len_reg <= st_rd[264:257];
        lpi8_reg <= st_rd[256];
        tabs_reg <= st_rd[255:0];
      end
    end
  end

  // ==========================================
  // Paper motion
  // One step per gap; the gap sets the motor's step rate
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      steps_reg <= 4'h0;
      timer_reg <= 20'h00000;
      lines_left_reg <= 8'h00;
      tab_run_reg <= 1'b0;
      motor_step <= 1'b0;
    end else if (clk_en) begin
      motor_step <= 1'b0;
      if (p_tab) begin
        tab_run_reg <= 1'b1;
      end
      if ((cr_in && !sw[5]) || p_lf || sw_lf) begin
        if (lines_left_reg != 8'hff) begin
          lines_left_reg <= lines_left_reg + 8'h01;
        end
      end
      case (state_reg)
        ST_IDLE: begin
          if (tab_run_reg || lines_left_reg != 8'h00) begin
            steps_reg <= lpi8_reg ? `PSV_STEPS_8LPI : `PSV_STEPS_6LPI;
            state_reg <= ST_STEP;
          end
        end
        ST_STEP: begin
          motor_step <= 1'b1;
          timer_reg <= 20'h00000;
          state_reg <= ST_GAP;
        end
        ST_GAP: begin
          if (timer_reg == STEP_LIM) begin
            steps_reg <= steps_reg - 4'h1;
            if (steps_reg == 4'h1) begin
              state_reg <= ST_IDLE;
              if (tab_run_reg) begin
                if (tab_stop) begin
                  tab_run_reg <= 1'b0;
                end
              end else if (!((cr_in && !sw[5]) || p_lf || sw_lf)) begin
                lines_left_reg <= lines_left_reg - 8'h01;
              end
            end else begin
              state_reg <= ST_STEP;
            end
          end else begin
            timer_reg <= timer_reg + 20'h00001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Switch decode
  reg [13:0] baud_next;
  always @* begin
    case (sw[2:0])
      3'b000: baud_next = `PSV_BAUD_110;
      3'b001: baud_next = alternate_rate_set ? `PSV_BAUD_200 : `PSV_BAUD_150;
      3'b010: baud_next = `PSV_BAUD_300;
      3'b011: baud_next = `PSV_BAUD_1200;
      3'b100: baud_next = `PSV_BAUD_2400;
      3'b101: baud_next = alternate_rate_set ? `PSV_BAUD_600 : `PSV_BAUD_4800;
      3'b110: baud_next = `PSV_BAUD_9600;
      default: baud_next = 14'h0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      baud_rate <= `PSV_BAUD_110;
      parallel_in_sel <= 1'b0;
      self_test_en <= 1'b1;
      parity_check_en <= 1'b0;
      parity_odd <= 1'b0;
      auto_lf_en <= 1'b1;
      perf_skip_en <= 1'b1;
      eight_line_spacing <= 1'b0;
    end else if (clk_en) begin
      baud_rate <= baud_next;
      parallel_in_sel <= (sw[2:0] == 3'b111);
      self_test_en <= (sw[2:0] != 3'b111);
      // Switch five alone is not a listed setting; it ignores parity
      parity_check_en <= sw[3];
      parity_odd <= sw[3] & sw[4];
      auto_lf_en <= ~sw[5];
      perf_skip_en <= ~sw[6];
      eight_line_spacing <= lpi8_reg;
    end
  end

  // ==========================================
  // Register read port
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `PSV_REG_CFG: reg_rdata <= {
            23'h000000,
            learn_reg,
            lpi8_reg,
            perf_skip_en,
            auto_lf_en,
            parity_odd,
            parity_check_en,
            parallel_in_sel,
            tab_run_reg
          };
          `PSV_REG_BAUD: reg_rdata <= {18'h00000, baud_rate};
          `PSV_REG_FORM: reg_rdata <= {24'h000000, form_len_reg};
          `PSV_REG_LINE: reg_rdata <= {24'h000000, line_count};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // psv_setup

//--- pkg/psv_regs.vh
// ==========================================
// How it works
// - Switches one-three pick standard baud rate
// - Alternate rate set swaps 150/4800 codes
// - All three on: parallel input, no self-test
// - Switches four-five pick ignore, odd, even parity
// - Switch six off adds line feed after return
// - Switch seven off skips three perforation lines
// - Basic config starts with 11 inch form
// - Software form length is lost at power-off
// - Set top in format mode zeroes counter
// - Second set top length, committed leaving mode
// - Tab set marks, tab clear unmarks current line
// - Tab advances to next tab or next form
// - Eight channels hold length, tabs, line spacing
// - Channel store keeps contents without power
// - Store working format to command channel, or from the panel to the channel given by channel_sel bits 2:1
// - Recall any channel by command into working format; panel recall uses channel_sel bits 2:1
// - Spacing switch selects eight lines, lights lamp
// - Alternate button functions only in format mode
// - One line is twelve or nine steps
`ifndef PSV_REGS_VH
`define PSV_REGS_VH

// ==========================================
// Timing
`define PSV_CLK_MHZ 100
`define PSV_DEB_US 10000
`define PSV_DEB_CYC (`PSV_DEB_US * `PSV_CLK_MHZ)
`define PSV_STEP_US 2000
`define PSV_STEP_CYC (`PSV_STEP_US * `PSV_CLK_MHZ)
`define PSV_STEPS_6LPI 4'hc
`define PSV_STEPS_8LPI 4'h9

// ==========================================
// Reset values
// 66 lines is 11 inch at six lines per inch
`define PSV_FORM_LEN_RST 8'h42

// ==========================================
// Register offsets
`define PSV_REG_CFG 8'h00
`define PSV_REG_BAUD 8'h04
`define PSV_REG_FORM 8'h08
`define PSV_REG_LINE 8'h0c
`define PSV_REG_CMD 8'h10

// ==========================================
// Command fields
`define PSV_CMD_STORE 0
`define PSV_CMD_RECALL 1
`define PSV_CMD_LF 2
`define PSV_CMD_LPI8 3
`define PSV_CMD_LPI6 4
`define PSV_CMD_CH_LO 8
`define PSV_CMD_CH_HI 10

// ==========================================
// Baud rates
`define PSV_BAUD_110 14'h006e
`define PSV_BAUD_150 14'h0096
`define PSV_BAUD_200 14'h00c8
`define PSV_BAUD_300 14'h012c
`define PSV_BAUD_600 14'h0258
`define PSV_BAUD_1200 14'h04b0
`define PSV_BAUD_2400 14'h0960
`define PSV_BAUD_4800 14'h12c0
`define PSV_BAUD_9600 14'h2580

`endif
